// ### rtl/adc_cfg_pkg.sv
/*
 Package for the converter configuration link: frame layout, field positions,
 reset values, power-mode and range encodings, timing constants.
 Assumes both link ends, the checker and the bench use it by scoped name only; the interface does not use it.
*/
package adc_cfg_pkg;
    // Frame geometry
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    // Header bit positions
    localparam int POS_WRITE = 15;
    localparam int POS_ZERO = 14;
    localparam int POS_REG_SEL = 13;
    // Control field positions
    localparam int POS_CHANNEL_ADDRESS_BIT = 10;
    localparam int POS_POWER_MODE_HI = 7;
    localparam int POS_POWER_MODE_LO = 6;
    localparam int POS_REF = 4;
    localparam int POS_SEQUENCER_SEL_HI = 3;
    localparam int POS_SEQUENCER_SEL_LO = 2;
    // Range field positions
    localparam int POS_CH0_RANGE_BIT_HI = 12;
    localparam int POS_CH0_RANGE_BIT_LO = 11;
    localparam int POS_CH1_RANGE_BIT_HI = 8;
    localparam int POS_CH1_RANGE_BIT_LO = 7;
    // Falling-edge counts at which data loads
    localparam logic [4:0] CTRL_LOAD_FALL = 5'h0f;
    localparam logic [4:0] RANGE_LOAD_FALL = 5'h0b;
    // Rising edge that enters auto modes
    localparam logic [4:0] AUTO_ENTER_RISE = 5'h0f;
    // Reset values
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [5:0] RANGE_RESET = 6'h00;
    // Power modes {hi,lo}
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_AUTO_STANDBY = 2'h1;
    localparam logic [1:0] PM_AUTO_SHUTDOWN = 2'h2;
    localparam logic [1:0] PM_FULL_SHUTDOWN = 2'h3;
    // Range codes
    localparam logic [1:0] RNG_PM10 = 2'h0;
    localparam logic [1:0] RNG_PM5 = 2'h1;
    localparam logic [1:0] RNG_PM2P5 = 2'h2;
    localparam logic [1:0] RNG_UNI10 = 2'h3;
    // Host register offsets
    localparam logic [1:0] HOST_REG_FRAME = 2'h0;
    localparam logic [1:0] HOST_REG_STATUS = 2'h1;
    // Reference settle time and system clock
    localparam int REF_SETTLE_US = 500;
    localparam int CLK_MHZ = 10;
    localparam int REF_SETTLE_CYC = REF_SETTLE_US * CLK_MHZ;
    // Link clock divider: half period in system cycles
    localparam int SCLK_HALF_CYC = 4;
endpackage

// ### rtl/adc_cfg_if.sv
/*
 Serial link between host controller and converter configuration logic.
 Assumes the host drives all three wires; the device only listens.
*/
`timescale 1ns/1ps
interface adc_cfg_if;
    logic sclk; // Serial clock, made by host
    logic cs_n; // Frame select, active low
    logic din; // Serial data into device
    modport host (output sclk, output cs_n, output din);
    modport device (input sclk, input cs_n, input din);
endinterface

// ### rtl/adc_cfg_device.sv
/*
 Device end: shifts 16-bit frames in from the link, loads the control and
 range registers, and derives power state, channel and range for conversion.
 Assumes link pins are asynchronous to i_clk and sampled through two flops.
*/
// Our own choices: strobed register access and the placing of the registers.
// Contract
// RULE1 - Full shutdown powers down, registers retained
// RULE2 - Auto shutdown entered on 15th rising edge
// RULE3 - Auto standby keeps only reference powered
// RULE4 - Normal mode keeps everything powered
// RULE5 - Sequencer 00/11: address bit picks channel
// RULE6 - Sequencer 10: channel 0 to final, wrap
// RULE7 - Sequencing uses each channel's latest range
// RULE8 - Host starts sequence with control write
// RULE9 - Idle or unwritten frames keep sequence
// RULE10 - Host clears sequencer bits to stop
// RULE11 - Range register six bits, write-only
// RULE12 - Header 1,0,1 selects range register
// RULE13 - Range codes map to four spans
// RULE14 - Ranges default to plus-minus 10 V
// RULE15 - Selected channel gets its stored range
// RULE16 - Reference bit: 1 internal, resets 0
// RULE17 - Reference enable frame result invalid
// RULE18 - Host waits 500 us for reference
// RULE19 - Header 1,0,0 selects control; write 0 ignored
// RULE20 - Control register resets to zero
// RULE21 - Control loads fall 15, range fall 11
// RULE22 - Control fields at bits 10, 7:6, 3:2
// RULE23 - Range frame: ch0 pair, 00, ch1 pair
`timescale 1ns/1ps
module adc_cfg_device (
    // System
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Link
    adc_cfg_if.device link,
    // Conversion configuration
    output logic [1:0] o_power_mode,
    output logic o_core_powered,
    output logic o_ref_powered,
    output logic o_ref_internal,
    output logic o_channel,
    output logic [1:0] o_range_code,
    output logic o_result_invalid,
    output logic o_conv_strobe
);
    // Synchronisers for link pins
    logic [1:0] sclk_sync_q;
    logic [1:0] cs_sync_q;
    logic [1:0] din_sync_q;
    logic sclk_prev_q; // Previous synced clock, for edge finding
    logic cs_prev_q;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic [4:0] fall_cnt_q; // Falling edges in this frame
    logic [4:0] rise_cnt_q; // Rising edges in this frame
    logic [15:0] shift_q; // Bits in arrival order, MSB first
    logic [15:0] shift_d;
    logic [11:0] ctrl_q; // Write-only control register
    logic [5:0] range_q; // Write-only range register
    logic ctrl_upd_q; // Control updated this frame
    logic asleep_q; // Auto mode powered down
    logic seq_ch_q; // Sequencer position
    logic ref_was_q; // Reference bit before this frame
    logic [1:0] pm;
    logic seq_on;

    // Two-flop synchronisers; first stage only feeds the second
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sclk_sync_q <= 2'h3; // Idle high, so no false edge after reset
            cs_sync_q <= 2'h3;
            din_sync_q <= 2'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[0], link.sclk};
            cs_sync_q <= {cs_sync_q[0], link.cs_n};
            din_sync_q <= {din_sync_q[0], link.din};
        end
    end

    // Edge history
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sclk_prev_q <= 1'b1; // Matches idle level of the link clock
            cs_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_sync_q[1];
            cs_prev_q <= cs_sync_q[1];
        end
    end

    assign sclk_rise = sclk_sync_q[1] & ~sclk_prev_q & ~cs_sync_q[1];
    assign sclk_fall = ~sclk_sync_q[1] & sclk_prev_q & ~cs_sync_q[1];
    assign cs_fall = ~cs_sync_q[1] & cs_prev_q;
    assign cs_rise = cs_sync_q[1] & ~cs_prev_q;
    assign shift_d = {shift_q[14:0], din_sync_q[1]};

    // Edge counters, cleared at each frame start
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fall_cnt_q <= 5'h00;
            rise_cnt_q <= 5'h00;
        end else if (cs_fall) begin
            fall_cnt_q <= 5'h00;
            rise_cnt_q <= 5'h00;
        end else begin
            if (sclk_fall && fall_cnt_q != 5'h1f) begin
                fall_cnt_q <= fall_cnt_q + 5'h01;
            end
            if (sclk_rise && rise_cnt_q != 5'h1f) begin
                rise_cnt_q <= rise_cnt_q + 5'h01;
            end
        end
    end

    // Data taken on link falling edges
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            shift_q <= 16'h0000;
        end else if (cs_fall) begin
            shift_q <= 16'h0000;
        end else if (sclk_fall) begin
            shift_q <= shift_d;
        end
    end

    // Control register load on 15th falling edge; header in bits 14:12 of shift_d
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_q <= adc_cfg_pkg::CTRL_RESET; // RULE20
            ctrl_upd_q <= 1'b0;
        end else if (cs_fall) begin
            ctrl_upd_q <= 1'b0;
        end else if (sclk_fall && fall_cnt_q == adc_cfg_pkg::CTRL_LOAD_FALL - 5'h01) begin
            // Bits arrived: 15 so far; shift_d[14]=write, [13]=zero, [12]=select
            if (shift_d[14] && !shift_d[13] && !shift_d[12]) begin // RULE19
                // Frame bits 11:1 sit in shift_d[10:0]; bit 0 not yet in, always written 0
                ctrl_q <= {shift_d[10:0], 1'b0}; // RULE21 RULE22
                ctrl_upd_q <= 1'b1;
            end
        end
    end

    // Range register load on 11th falling edge, bits 10:0 arrived
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            range_q <= adc_cfg_pkg::RANGE_RESET; // RULE14
        end else if (sclk_fall && fall_cnt_q == adc_cfg_pkg::RANGE_LOAD_FALL - 5'h01) begin
            if (shift_d[10] && !shift_d[9] && shift_d[8]) begin // RULE12
                // Ch0 pair, two zeros, ch1 pair
                range_q <= {shift_d[7:6], 2'h0, shift_d[3:2]}; // RULE11 RULE23
            end
        end
    end

    // Control fields, frame bit n sits at ctrl_q[n]
    assign pm = {ctrl_q[adc_cfg_pkg::POS_POWER_MODE_HI], ctrl_q[adc_cfg_pkg::POS_POWER_MODE_LO]};
    // Only pattern 10 sequences; 00 and 11 address directly
    assign seq_on = ctrl_q[adc_cfg_pkg::POS_SEQUENCER_SEL_HI] & ~ctrl_q[adc_cfg_pkg::POS_SEQUENCER_SEL_LO];

    // Auto sleep: down at 15th rising edge after update, up at frame end
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            asleep_q <= 1'b0;
        end else if (cs_rise) begin
            asleep_q <= 1'b0;
        end else if (sclk_rise && rise_cnt_q == adc_cfg_pkg::AUTO_ENTER_RISE - 5'h01 &&
                     (pm == adc_cfg_pkg::PM_AUTO_SHUTDOWN || pm == adc_cfg_pkg::PM_AUTO_STANDBY)) begin
            asleep_q <= 1'b1; // RULE2 RULE3
        end
    end

    // Power outputs; full shutdown holds until bits rewritten, registers kept
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_power_mode <= adc_cfg_pkg::PM_NORMAL;
            o_core_powered <= 1'b1;
            o_ref_powered <= 1'b0;
            o_ref_internal <= 1'b0; // External reference after reset
        end else begin
            o_power_mode <= pm;
            unique case (pm)
                adc_cfg_pkg::PM_NORMAL: begin
                    o_core_powered <= 1'b1; // RULE4
                    o_ref_powered <= ctrl_q[adc_cfg_pkg::POS_REF];
                end
                adc_cfg_pkg::PM_FULL_SHUTDOWN: begin
                    o_core_powered <= 1'b0; // RULE1
                    o_ref_powered <= 1'b0;
                end
                adc_cfg_pkg::PM_AUTO_SHUTDOWN: begin
                    o_core_powered <= ~asleep_q; // RULE2
                    o_ref_powered <= ~asleep_q & ctrl_q[adc_cfg_pkg::POS_REF];
                end
                adc_cfg_pkg::PM_AUTO_STANDBY: begin
                    o_core_powered <= ~asleep_q; // RULE3
                    o_ref_powered <= ctrl_q[adc_cfg_pkg::POS_REF];
                end
            endcase
            o_ref_internal <= ctrl_q[adc_cfg_pkg::POS_REF]; // RULE16
        end
    end

    // Sequencer advances at each frame end without a control write; idle frames keep it running
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            seq_ch_q <= 1'b0;
        end else if (cs_rise) begin
            if (!seq_on || ctrl_upd_q) begin
                seq_ch_q <= 1'b0; // Restart from channel 0 on new config
            end else if (seq_ch_q == ctrl_q[adc_cfg_pkg::POS_CHANNEL_ADDRESS_BIT]) begin
                seq_ch_q <= 1'b0; // RULE6
            end else begin
                seq_ch_q <= 1'b1; // RULE9
            end
        end
    end

    // Channel and its range for the next conversion
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_channel <= 1'b0;
            o_range_code <= adc_cfg_pkg::RNG_PM10;
        end else begin
            o_channel <= seq_on ? seq_ch_q : ctrl_q[adc_cfg_pkg::POS_CHANNEL_ADDRESS_BIT]; // RULE5
            // RULE7 RULE15 RULE13: code passed as stored, 00/01/10/11 spans
            o_range_code <= (seq_on ? seq_ch_q : ctrl_q[adc_cfg_pkg::POS_CHANNEL_ADDRESS_BIT]) ?
                            range_q[1:0] : range_q[5:4];
        end
    end

    // Result of frame that turns on internal reference is invalid
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ref_was_q <= 1'b0;
            o_result_invalid <= 1'b0;
            o_conv_strobe <= 1'b0;
        end else begin
            o_conv_strobe <= cs_fall;
            if (cs_fall) begin
                ref_was_q <= ctrl_q[adc_cfg_pkg::POS_REF];
                o_result_invalid <= 1'b0;
            end else if (ctrl_upd_q && ctrl_q[adc_cfg_pkg::POS_REF] && !ref_was_q) begin
                o_result_invalid <= 1'b1; // RULE17
            end
        end
    end
endmodule

// ### rtl/adc_cfg_host.sv
/*
 Host end: takes 16-bit frames from software through a small register port
 and shifts them out over the link with a divided serial clock.
 Assumes software sees status one cycle after the read strobe.
*/
`timescale 1ns/1ps
module adc_cfg_host (
    // System
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Software port
    input wire logic [1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Link
    adc_cfg_if.host link
);
    typedef enum logic [1:0] {IDLE, SHIFT, GAP} host_state_e;
    host_state_e state_q;
    logic [15:0] frame_q; // Frame being sent, MSB first
    logic [4:0] bit_q; // Bits left
    logic [2:0] div_q; // Half-period divider
    logic pend_q; // Frame queued
    logic [15:0] pend_frame_q;
    logic ref_on_q; // Reference just enabled
    logic [12:0] settle_q; // Reference settle countdown
    logic sclk_q, cs_n_q, din_q;

    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign link.din = din_q;

    // Software writes queue one frame; a write while pending replaces it
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pend_q <= 1'b0;
            pend_frame_q <= 16'h0000;
        end else if (i_wr && i_addr == adc_cfg_pkg::HOST_REG_FRAME) begin
            pend_q <= 1'b1; // RULE8 RULE10 RULE12 RULE19
            pend_frame_q <= i_wdata;
        end else if (state_q == IDLE && pend_q) begin
            pend_q <= 1'b0;
        end
    end

    // Frame engine; data changes on rising edge, device samples on falling
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= IDLE;
            sclk_q <= 1'b1;
            cs_n_q <= 1'b1;
            din_q <= 1'b0;
            frame_q <= 16'h0000;
            bit_q <= 5'h00;
            div_q <= 3'h0;
        end else begin
            unique case (state_q)
                IDLE: begin
                    din_q <= 1'b0; // RULE9
                    if (pend_q) begin
                        cs_n_q <= 1'b0;
                        frame_q <= pend_frame_q;
                        bit_q <= 5'h10;
                        div_q <= 3'h0;
                        state_q <= SHIFT;
                    end
                end
                SHIFT: begin
                    if (div_q == 3'(adc_cfg_pkg::SCLK_HALF_CYC - 1)) begin
                        div_q <= 3'h0;
                        if (sclk_q) begin
                            if (bit_q == 5'h00) begin
                                cs_n_q <= 1'b1;
                                state_q <= GAP;
                            end else begin
                                sclk_q <= 1'b0;
                                bit_q <= bit_q - 5'h01;
                            end
                        end else begin
                            sclk_q <= 1'b1;
                            din_q <= frame_q[14];
                            frame_q <= {frame_q[14:0], 1'b0};
                        end
                    end else begin
                        div_q <= div_q + 3'h1;
                        if (div_q == 3'h0 && sclk_q && bit_q == 5'h10) begin
                            din_q <= frame_q[15];
                        end
                    end
                end
                GAP: begin
                    if (div_q == 3'(adc_cfg_pkg::SCLK_HALF_CYC - 1)) begin
                        div_q <= 3'h0;
                        state_q <= IDLE;
                    end else begin
                        div_q <= div_q + 3'h1;
                    end
                end
                default: state_q <= IDLE;
            endcase
        end
    end

    // Reference settle countdown after a control frame setting the reference bit
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ref_on_q <= 1'b0;
            settle_q <= 13'h0000;
        end else if (state_q == IDLE && pend_q && pend_frame_q[15:13] == 3'h4 &&
                     pend_frame_q[adc_cfg_pkg::POS_REF]) begin
            ref_on_q <= 1'b1;
            settle_q <= 13'(adc_cfg_pkg::REF_SETTLE_CYC); // RULE18
        end else if (settle_q != 13'h0000) begin
            settle_q <= settle_q - 13'h0001;
        end
    end

    // Read data one cycle after strobe
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            if (i_addr == adc_cfg_pkg::HOST_REG_STATUS) begin
                o_rdata <= {13'h0000, ref_on_q & (settle_q == 13'h0000), pend_q, state_q != IDLE}; // RULE18
            end else begin
                o_rdata <= 16'h0000;
            end
        end else begin
            o_rdata <= 16'h0000;
        end
    end
endmodule

// ### testbench/adc_cfg_checker.sv
/*
 Checker for the converter configuration link: frame framing on the wires
 and the power, channel and reference outputs of the device end.
 Assumes the bench top instantiates it beside the link interface.
*/
`timescale 1ns/1ps
module adc_cfg_checker (
    // System
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    // Device outputs
    input wire logic [1:0] o_power_mode,
    input wire logic o_core_powered,
    input wire logic o_ref_powered,
    input wire logic o_ref_internal,
    input wire logic o_channel,
    input wire logic [1:0] o_range_code,
    input wire logic o_result_invalid,
    input wire logic o_conv_strobe
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic [4:0] falls_q; // Serial clock falls in this frame
    logic sclk_q; // Serial clock one cycle ago
    // Count falls while selected; idle clears, so a short frame shows up
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            falls_q <= 5'h00;
            sclk_q <= 1'b1;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                falls_q <= 5'h00;
            end else if (sclk_q && !sclk) begin
                falls_q <= falls_q + 5'h01;
            end
        end
    end
    AST_FULL_SD: assert property ((o_power_mode == adc_cfg_pkg::PM_FULL_SHUTDOWN) && cs_n
        |-> !o_core_powered && !o_ref_powered) else $error("core or reference on in full shutdown");
    AST_AUTO_WAKE: assert property ((o_power_mode[1] ^ o_power_mode[0]) && $rose(cs_n)
        |-> ##[1:6] o_core_powered) else $error("no wake after frame end in auto mode");
    AST_AUTO_SLEEP: assert property ($fell(o_core_powered) |-> !cs_n)
        else $error("core went down outside a frame");
    AST_STANDBY_REF: assert property ((o_power_mode == adc_cfg_pkg::PM_AUTO_STANDBY) && o_ref_internal
        |-> ##[0:4] o_ref_powered) else $error("reference down in auto standby");
    // Mode and core flag leave the same edge, so they must agree in every cycle
    AST_NORMAL_ON: assert property ((o_power_mode == adc_cfg_pkg::PM_NORMAL) |-> o_core_powered)
        else $error("core down in normal mode");
    // Strobe follows the synchronised frame start by a fixed delay
    AST_CONV_STROBE: assert property ($fell(cs_n) |-> ##[2:4] o_conv_strobe)
        else $error("no conversion strobe after frame start");
    AST_CONV_PULSE: assert property (o_conv_strobe |=> !o_conv_strobe)
        else $error("conversion strobe longer than one cycle");
    AST_IDLE_STABLE: assert property (cs_n[*8]
        |-> $stable({o_channel, o_range_code, o_power_mode, o_ref_internal})) else $error("config moved while idle");
    AST_INVALID_CLR: assert property ($fell(cs_n) |-> ##[1:6] !o_result_invalid)
        else $error("invalid flag kept into next frame");
    AST_INVALID_SET: assert property ($rose(o_result_invalid) |-> !cs_n)
        else $error("invalid flag raised outside a frame");
    AST_FRAME_FALLS: assert property ($rose(cs_n) |-> (falls_q == 5'h10) && sclk)
        else $error("frame did not carry sixteen falls");
    // Main scenarios reached
    cover property ((o_power_mode == adc_cfg_pkg::PM_FULL_SHUTDOWN) && cs_n);
    cover property ($rose(o_result_invalid));
    cover property (o_channel && cs_n && $changed(o_channel));
endmodule

// ### testbench/adc_mode_range_sequencer_ctrl_tb_top.sv
/*
 Bench top: host end drives device end over the link; software port
 frames are checked against the settled device outputs.
 Assumes one 10 MHz clock for both ends and the package constants.
*/
`timescale 1ns/1ps
module adc_mode_range_sequencer_ctrl_tb_top;
    // One row: frame and settled outputs it should leave
    typedef struct packed {
        logic [15:0] frame;
        logic [1:0] pm;
        logic core;
        logic ch;
        logic [1:0] rng;
        logic ref_int;
    } row_s;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [1:0] i_addr = 2'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic [1:0] o_power_mode;
    logic o_core_powered, o_ref_powered, o_ref_internal, o_channel;
    logic [1:0] o_range_code;
    logic o_result_invalid, o_conv_strobe;
    int mismatches = 0;
    int total_checks = 0;
    row_s rows [13];
    logic [15:0] st; // Last status word read
    adc_cfg_if adc_cfg_if_inst ();
    adc_cfg_host adc_cfg_host_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(adc_cfg_if_inst.host));
    adc_cfg_device adc_cfg_device_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(adc_cfg_if_inst.device),
        .o_power_mode(o_power_mode), .o_core_powered(o_core_powered), .o_ref_powered(o_ref_powered),
        .o_ref_internal(o_ref_internal), .o_channel(o_channel), .o_range_code(o_range_code),
        .o_result_invalid(o_result_invalid), .o_conv_strobe(o_conv_strobe));
    adc_cfg_checker adc_cfg_checker_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .sclk(adc_cfg_if_inst.sclk),
        .cs_n(adc_cfg_if_inst.cs_n), .o_power_mode(o_power_mode), .o_core_powered(o_core_powered),
        .o_ref_powered(o_ref_powered), .o_ref_internal(o_ref_internal), .o_channel(o_channel),
        .o_range_code(o_range_code), .o_result_invalid(o_result_invalid), .o_conv_strobe(o_conv_strobe));
    // Free-running system clock
    always #50 i_clk = ~i_clk;
    // Verdict and end of run
    task automatic finish_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic fail(string msg);
        mismatches++;
        $display("Error at %0t: %s", $time, msg);
    endtask
    // One-cycle write strobe on the software port
    task automatic sw_write(logic [1:0] a, logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read strobe; data stands only in the next cycle, sampled mid-cycle
    task automatic sw_read(logic [1:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask
    // Poll busy and pending, bounded; then let synchronisers settle
    task automatic wait_idle();
        int n;
        n = 0;
        st = 16'h0003;
        while (st[1:0] !== 2'b00) begin
            if (n == 400) begin
                fail("link never went idle");
                finish_test();
            end
            sw_read(adc_cfg_pkg::HOST_REG_STATUS, st);
            n++;
        end
        repeat (12) @(posedge i_clk);
    endtask
    task automatic check_cfg(row_s r);
        total_checks++;
        if ({o_power_mode, o_core_powered, o_channel, o_range_code, o_ref_internal} !==
            {r.pm, r.core, r.ch, r.rng, r.ref_int}) begin
            fail($sformatf("outputs wrong after frame %h", r.frame));
        end
    endtask
    task automatic check_bit(logic got, logic exp, string what);
        total_checks++;
        if (got !== exp) begin
            fail(what);
        end
    endtask
    // Main sequence
    initial begin
        // Ranges ch0 01 ch1 10, then single, reference, ignored, shutdown, sequencer
        rows[0] = '{16'ha900, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0};
        rows[1] = '{16'h8400, 2'h0, 1'b1, 1'b1, 2'h2, 1'b0};
        rows[2] = '{16'h8010, 2'h0, 1'b1, 1'b0, 2'h1, 1'b1};
        rows[3] = '{16'h0400, 2'h0, 1'b1, 1'b0, 2'h1, 1'b1};
        rows[4] = '{16'h80c0, 2'h3, 1'b0, 1'b0, 2'h1, 1'b0};
        rows[5] = '{16'h8408, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0};
        rows[6] = '{16'h0000, 2'h0, 1'b1, 1'b1, 2'h2, 1'b0};
        rows[7] = '{16'h0000, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0};
        rows[8] = '{16'h840c, 2'h0, 1'b1, 1'b1, 2'h2, 1'b0};
        rows[9] = '{16'h8080, 2'h2, 1'b1, 1'b0, 2'h1, 1'b0};
        rows[10] = '{16'h8050, 2'h1, 1'b1, 1'b0, 2'h1, 1'b1};
        rows[11] = '{16'hb980, 2'h1, 1'b1, 1'b0, 2'h3, 1'b1};
        rows[12] = '{16'h8000, 2'h0, 1'b1, 1'b0, 2'h3, 1'b0};
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        foreach (rows[i]) begin
            sw_write(adc_cfg_pkg::HOST_REG_FRAME, rows[i].frame);
            wait_idle();
            check_cfg(rows[i]);
        end
        // Back-to-back writes: the last one replaces the pending frame
        sw_write(adc_cfg_pkg::HOST_REG_FRAME, 16'h8080);
        sw_write(adc_cfg_pkg::HOST_REG_FRAME, 16'h8400);
        sw_write(adc_cfg_pkg::HOST_REG_FRAME, 16'h8010);
        wait_idle();
        check_cfg('{16'h8010, 2'h0, 1'b1, 1'b0, 2'h3, 1'b1});
        check_bit(o_result_invalid, 1'b1, "result not flagged after reference enable");
        check_bit(st[2], 1'b0, "reference settled too early");
        repeat (5000) @(posedge i_clk);
        sw_read(adc_cfg_pkg::HOST_REG_STATUS, st);
        check_bit(st[2], 1'b1, "reference never settled");
        // Unmapped address read must not disturb anything
        sw_read(2'h3, st);
        // Reset in mid-run restores defaults
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_clk);
        check_cfg('{16'h0000, 2'h0, 1'b1, 1'b0, 2'h0, 1'b0});
        check_bit(o_ref_powered, 1'b0, "reference powered after reset");
        sw_write(adc_cfg_pkg::HOST_REG_FRAME, 16'h8400);
        wait_idle();
        check_cfg('{16'h8400, 2'h0, 1'b1, 1'b1, 2'h0, 1'b0});
        finish_test();
    end
endmodule
